// *** hdl/gated_timer_pkg.sv ***
// Constants, types and register layout of the gated 16-bit timer/counter
package gated_timer_pkg;

  // Register byte offsets, one aligned 32-bit word each
  localparam logic [11:0] OFF_COUNT_LOW = 12'h000;
  localparam logic [11:0] OFF_COUNT_HIGH = 12'h004;
  localparam logic [11:0] OFF_TIMER_CONTROL = 12'h008;
  localparam logic [11:0] OFF_GATE_CONTROL = 12'h00C;
  localparam logic [11:0] OFF_CLOCK_SELECT = 12'h010;

  // Field positions in timer_control_reg
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_ASYNC_BIT = 1;
  localparam int CTRL_PRESCALE_LSB = 4;
  localparam int CTRL_PRESCALE_MSB = 5;

  // Field positions in timer_gate_control_reg
  localparam int GATE_ENABLE_BIT = 0;
  localparam int GATE_POLARITY_BIT = 1;
  localparam int GATE_SEL_LSB = 4;
  localparam int GATE_SEL_MSB = 7;
  localparam int GATE_LEVEL_BIT = 8;

  // Field positions in timer_clock_select_reg
  localparam int CLK_SEL_LSB = 0;
  localparam int CLK_SEL_MSB = 3;

  // Clock source codes; all other codes stop the count
  localparam logic [3:0] CS_INSTR = 4'h0;
  localparam logic [3:0] CS_FOSC = 4'h1;
  localparam logic [3:0] CS_PIN = 4'h2;

  // Gate source codes; codes above GSEL_ZERO_CROSS read a low gate
  localparam logic [3:0] GSEL_PIN = 4'h0;
  localparam logic [3:0] GSEL_BYTE_TIMER = 4'h1;
  localparam logic [3:0] GSEL_SIBLING0 = 4'h2;
  localparam logic [3:0] GSEL_SIBLING1 = 4'h3;
  localparam logic [3:0] GSEL_PERIOD0 = 4'h4;
  localparam logic [3:0] GSEL_PERIOD1 = 4'h5;
  localparam logic [3:0] GSEL_PERIOD2 = 4'h6;
  localparam logic [3:0] GSEL_CCP0 = 4'h7;
  localparam logic [3:0] GSEL_CCP1 = 4'h8;
  localparam logic [3:0] GSEL_PWM0 = 4'h9;
  localparam logic [3:0] GSEL_PWM1 = 4'hA;
  localparam logic [3:0] GSEL_CMP0 = 4'hB;
  localparam logic [3:0] GSEL_CMP1 = 4'hC;
  localparam logic [3:0] GSEL_ZERO_CROSS = 4'hD;

  // Four oscillator cycles make one instruction cycle
  localparam logic [1:0] INSTR_LAST_PHASE = 2'h3;

  // APB answer sequencing
  typedef enum logic {APB_IDLE, APB_ANSWER} apbPhase_e;

  // Internal peripheral outputs offered to the gate multiplexer
  typedef struct packed {
    logic byteTimerOutput;
    logic [1:0] siblingCounterOutput;
    logic [2:0] periodTimerOutput;
    logic [1:0] captureCompareOutput;
    logic [1:0] pulseWidthOutput;
    logic [1:0] comparatorOutput;
    logic zeroCrossOutput;
  } gateSources_s;

  // Whole state of the timer block
  typedef struct packed {
    apbPhase_e phase;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [15:0] count;
    logic overflow;
    logic enable;
    logic asyncSel;
    logic [1:0] prescale;
    logic gateEnable;
    logic gatePolarity;
    logic [3:0] gateSel;
    logic [3:0] clkSel;
    logic [2:0] pinSync;
    logic pinLevel;
    logic [2:0] gatePinSync;
    logic gatePinLevel;
    logic armed;
    logic pendEdge;
    logic [1:0] instrPhase;
    logic [2:0] preCnt;
  } state_s;

  // Everything off and idle after reset
  localparam state_s STATE_RESET = '0;

endpackage

// *** hdl/gated_timer_counter.sv ***
// Gated 16-bit timer/counter with APB register access
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps

module gated_timer_counter (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic externalCountInput,
  input wire logic gatePinInput,
  input wire gated_timer_pkg::gateSources_s gateSources,
  output logic [15:0] countValue,
  output logic overflowPulse
);

  // Reset release pipe, active low copy used everywhere else
  logic [1:0] rstPipe;
  logic rstnSync;
  // Registered state and its next value
  gated_timer_pkg::state_s q;
  gated_timer_pkg::state_s d;
  // Decoded helpers, all combinational
  logic instrTick;
  logic pinRise;
  logic pinFall;
  logic gateRaw;
  logic gateActive;
  logic runEn;
  logic baseTick;
  logic [2:0] preTop;
  logic preLast;
  logic incTick;
  logic access;
  logic addrHit;
  logic [7:0] wrByte;
  logic wrOk;

  // Reset synchroniser; it runs even with ce low so reset always lands
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      rstPipe <= 2'h0;
    else
      rstPipe <= {rstPipe[0], 1'h1};
  end
  // Only the second stage is used; the first may still be settling
  assign rstnSync = rstPipe[1];

  // Next-state logic for the whole block
  always_comb
  begin
    d = q;
    // Free-running instruction phase, Fosc divided by four
    instrTick = (q.instrPhase == gated_timer_pkg::INSTR_LAST_PHASE);
    d.instrPhase = q.instrPhase + 2'h1;

    // Pin synchronisers: stage 0 feeds stage 1 only
    d.pinSync = {q.pinSync[1:0], externalCountInput};
    d.gatePinSync = {q.gatePinSync[1:0], gatePinInput};
    // A level is taken once stages 1 and 2 agree
    if (q.pinSync[1] == q.pinSync[2])
      d.pinLevel = q.pinSync[2];
    if (q.gatePinSync[1] == q.gatePinSync[2])
      d.gatePinLevel = q.gatePinSync[2];
    pinRise = (q.pinSync[1] == q.pinSync[2]) && q.pinSync[2] && !q.pinLevel;
    pinFall = (q.pinSync[1] == q.pinSync[2]) && !q.pinSync[2] && q.pinLevel;

    // Gate source multiplexer; unused codes give a low gate
    case (q.gateSel)
      gated_timer_pkg::GSEL_PIN: gateRaw = q.gatePinLevel;
      gated_timer_pkg::GSEL_BYTE_TIMER: gateRaw = gateSources.byteTimerOutput;
      gated_timer_pkg::GSEL_SIBLING0: gateRaw = gateSources.siblingCounterOutput[0];
      gated_timer_pkg::GSEL_SIBLING1: gateRaw = gateSources.siblingCounterOutput[1];
      gated_timer_pkg::GSEL_PERIOD0: gateRaw = gateSources.periodTimerOutput[0];
      gated_timer_pkg::GSEL_PERIOD1: gateRaw = gateSources.periodTimerOutput[1];
      gated_timer_pkg::GSEL_PERIOD2: gateRaw = gateSources.periodTimerOutput[2];
      gated_timer_pkg::GSEL_CCP0: gateRaw = gateSources.captureCompareOutput[0];
      gated_timer_pkg::GSEL_CCP1: gateRaw = gateSources.captureCompareOutput[1];
      gated_timer_pkg::GSEL_PWM0: gateRaw = gateSources.pulseWidthOutput[0];
      gated_timer_pkg::GSEL_PWM1: gateRaw = gateSources.pulseWidthOutput[1];
      gated_timer_pkg::GSEL_CMP0: gateRaw = gateSources.comparatorOutput[0];
      gated_timer_pkg::GSEL_CMP1: gateRaw = gateSources.comparatorOutput[1];
      gated_timer_pkg::GSEL_ZERO_CROSS: gateRaw = gateSources.zeroCrossOutput;
      default: gateRaw = 1'h0;
    endcase
    // Polarity bit names the active level
    gateActive = (gateRaw == q.gatePolarity);
    // Off, always on, or gated
    runEn = q.enable && (!q.gateEnable || gateActive);

    // Falling edge arms the pin counter; disabling disarms it
    if (!q.enable)
      d.armed = 1'h0;
    else if (pinFall)
      d.armed = 1'h1;
    // Instruction-aligned pin edges wait here; set beats the clear
    d.pendEdge = (q.pendEdge && !instrTick) || (pinRise && q.armed && !q.asyncSel);
    if (!q.enable)
      d.pendEdge = 1'h0;

    // Source selection
    case (q.clkSel)
      gated_timer_pkg::CS_INSTR: baseTick = instrTick;
      gated_timer_pkg::CS_FOSC: baseTick = 1'h1;
      // Immediate mode trades instruction alignment for latency
      gated_timer_pkg::CS_PIN: baseTick = q.asyncSel ? (pinRise && q.armed) : (q.pendEdge && instrTick);
      default: baseTick = 1'h0;
    endcase

    // Prescaler ratio 1, 2, 4 or 8
    preTop = (3'h1 << q.prescale) - 3'h1;
    // At or past the top, so a ratio cut mid-count wraps at once instead of
    // running the 3-bit counter all the way round
    preLast = (q.preCnt >= preTop);
    incTick = runEn && baseTick && preLast;
    if (!q.enable)
      d.preCnt = 3'h0;
    else if (runEn && baseTick)
      d.preCnt = preLast ? 3'h0 : q.preCnt + 3'h1;

    // Counter advance with one-cycle wrap pulse
    d.overflow = 1'h0;
    if (incTick)
    begin
      d.count = q.count + 16'h0001;
      d.overflow = (q.count == 16'hFFFF);
    end

    // APB slave, answer one cycle into the access phase
    access = psel && penable;
    addrHit = (paddr == gated_timer_pkg::OFF_COUNT_LOW) || (paddr == gated_timer_pkg::OFF_COUNT_HIGH) ||
              (paddr == gated_timer_pkg::OFF_TIMER_CONTROL) || (paddr == gated_timer_pkg::OFF_GATE_CONTROL) ||
              (paddr == gated_timer_pkg::OFF_CLOCK_SELECT);
    wrByte = pwdata[7:0];
    // Only the low byte lane carries writable bits; a cleared strobe is a no-op
    wrOk = access && pwrite && pstrb[0] && !q.pslverr;
    d.pready = 1'h0;
    d.pslverr = 1'h0;
    unique case (q.phase)
      gated_timer_pkg::APB_IDLE:
      begin
        if (access)
        begin
          d.phase = gated_timer_pkg::APB_ANSWER;
          d.pready = 1'h1;
          d.pslverr = !addrHit;
          d.prdata = 32'h0000_0000;
          // Read data captured now, stands while pready is high
          if (!pwrite)
          begin
            case (paddr)
              gated_timer_pkg::OFF_COUNT_LOW: d.prdata[7:0] = q.count[7:0];
              gated_timer_pkg::OFF_COUNT_HIGH: d.prdata[7:0] = q.count[15:8];
              gated_timer_pkg::OFF_TIMER_CONTROL:
              begin
                d.prdata[gated_timer_pkg::CTRL_ENABLE_BIT] = q.enable;
                d.prdata[gated_timer_pkg::CTRL_ASYNC_BIT] = q.asyncSel;
                d.prdata[gated_timer_pkg::CTRL_PRESCALE_MSB:gated_timer_pkg::CTRL_PRESCALE_LSB] = q.prescale;
              end
              gated_timer_pkg::OFF_GATE_CONTROL:
              begin
                d.prdata[gated_timer_pkg::GATE_ENABLE_BIT] = q.gateEnable;
                d.prdata[gated_timer_pkg::GATE_POLARITY_BIT] = q.gatePolarity;
                d.prdata[gated_timer_pkg::GATE_SEL_MSB:gated_timer_pkg::GATE_SEL_LSB] = q.gateSel;
                d.prdata[gated_timer_pkg::GATE_LEVEL_BIT] = gateActive;
              end
              gated_timer_pkg::OFF_CLOCK_SELECT:
                d.prdata[gated_timer_pkg::CLK_SEL_MSB:gated_timer_pkg::CLK_SEL_LSB] = q.clkSel;
              default: d.prdata = 32'h0000_0000;
            endcase
          end
        end
      end
      gated_timer_pkg::APB_ANSWER:
      begin
        d.phase = gated_timer_pkg::APB_IDLE;
        // Writes land on the completing edge only
        if (wrOk)
        begin
          case (paddr)
            gated_timer_pkg::OFF_COUNT_LOW, gated_timer_pkg::OFF_COUNT_HIGH:
            begin
              // A load beats the advance in the same cycle
              if (paddr == gated_timer_pkg::OFF_COUNT_LOW)
                d.count = {q.count[15:8], wrByte};
              else
                d.count = {wrByte, q.count[7:0]};
              d.overflow = 1'h0;
              d.armed = 1'h0;
              d.pendEdge = 1'h0;
              d.preCnt = 3'h0;
            end
            gated_timer_pkg::OFF_TIMER_CONTROL:
            begin
              d.enable = wrByte[gated_timer_pkg::CTRL_ENABLE_BIT];
              d.asyncSel = wrByte[gated_timer_pkg::CTRL_ASYNC_BIT];
              d.prescale = wrByte[gated_timer_pkg::CTRL_PRESCALE_MSB:gated_timer_pkg::CTRL_PRESCALE_LSB];
            end
            gated_timer_pkg::OFF_GATE_CONTROL:
            begin
              d.gateEnable = wrByte[gated_timer_pkg::GATE_ENABLE_BIT];
              d.gatePolarity = wrByte[gated_timer_pkg::GATE_POLARITY_BIT];
              d.gateSel = wrByte[gated_timer_pkg::GATE_SEL_MSB:gated_timer_pkg::GATE_SEL_LSB];
            end
            gated_timer_pkg::OFF_CLOCK_SELECT:
              d.clkSel = wrByte[gated_timer_pkg::CLK_SEL_MSB:gated_timer_pkg::CLK_SEL_LSB];
            default: d.clkSel = q.clkSel;
          endcase
        end
      end
    endcase
  end

  // State register; ce low freezes everything
  // Reset comes from the synchronised copy, so no flop leaves reset an edge
  // ahead of its neighbours
  always_ff @(posedge sys_clk or negedge rstnSync)
  begin
    if (!rstnSync)
      q <= gated_timer_pkg::STATE_RESET;
    else if (ce)
      q <= d;
  end

  // Outputs straight from the state register
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign countValue = q.count;
  assign overflowPulse = q.overflow;

  // Checks on the counting behaviour
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstnSync || !ce);
  // Most checks pause in reset and while ce is low; a frozen cycle would
  // otherwise look like a missed count

  // Completing write to a count byte
  logic wrLow;
  logic wrHigh;
  assign wrLow = (q.phase == gated_timer_pkg::APB_ANSWER) && wrOk && (paddr == gated_timer_pkg::OFF_COUNT_LOW);
  assign wrHigh = (q.phase == gated_timer_pkg::APB_ANSWER) && wrOk && (paddr == gated_timer_pkg::OFF_COUNT_HIGH);

  // Four free-running oscillator cycles with no loads
  sequence foscRun4;
    (q.clkSel == gated_timer_pkg::CS_FOSC && q.prescale == 2'h0 && runEn && !wrLow && !wrHigh)[*4];
  endsequence

  count_step_a: assert property (incTick && !wrLow && !wrHigh |=> q.count == $past(q.count) + 16'h0001)
    else $error("count did not step by one");
  low_load_a: assert property (wrLow |=> q.count[7:0] == $past(pwdata[7:0]))
    else $error("low byte write not loaded");
  high_load_a: assert property (wrHigh |=> q.count == {$past(pwdata[7:0]), $past(q.count[7:0])})
    else $error("high byte write not loaded");
  instr_rate_a: assert property (q.clkSel == gated_timer_pkg::CS_INSTR && incTick |-> instrTick)
    else $error("internal source counted off instruction cycle");
  pin_rise_a: assert property (q.clkSel == gated_timer_pkg::CS_PIN && q.asyncSel && q.prescale == 2'h0 && runEn
    && pinRise && q.armed && !wrLow && !wrHigh |=> q.count == $past(q.count) + 16'h0001)
    else $error("pin rise not counted");
  off_hold_a: assert property (!q.enable && !wrLow && !wrHigh |=> $stable(q.count))
    else $error("disabled counter moved");
  bad_source_a: assert property (q.clkSel > gated_timer_pkg::CS_PIN |-> !incTick)
    else $error("unused source code counted");
  prescale_gap_a: assert property (q.prescale == 2'h3 && incTick |=> !incTick [*7])
    else $error("prescaler by eight counted too soon");
  fosc_four_a: assert property (foscRun4 |-> q.count == $past(q.count, 3) + 16'h0003)
    else $error("oscillator source not four per instruction");
  zero_cross_a: assert property (q.gateSel == gated_timer_pkg::GSEL_ZERO_CROSS |-> gateRaw == gateSources.zeroCrossOutput)
    else $error("gate mux picked wrong source");
  unarmed_a: assert property (q.clkSel == gated_timer_pkg::CS_PIN && !q.armed && !q.pendEdge |-> !incTick)
    else $error("pin counted without falling edge");
  sync_align_a: assert property (q.clkSel == gated_timer_pkg::CS_PIN && !q.asyncSel && incTick |-> instrTick)
    else $error("synchronised pin edge not aligned");
  gate_hold_a: assert property (q.gateEnable && !gateActive && !wrLow && !wrHigh |=> $stable(q.count))
    else $error("count moved with gate inactive");

  // Gate open with the fastest source counts every cycle
  gate_open_a: assert property (q.enable && q.gateEnable && gateActive && q.clkSel == gated_timer_pkg::CS_FOSC
    && q.prescale == 2'h0 && !wrLow && !wrHigh |=> q.count == $past(q.count) + 16'h0001)
    else $error("count held with gate active");
  // Enable without gating never skips a tick
  free_run_a: assert property (q.enable && !q.gateEnable && q.clkSel == gated_timer_pkg::CS_FOSC
    && q.prescale == 2'h0 && !wrLow && !wrHigh |=> q.count == $past(q.count) + 16'h0001)
    else $error("free-running counter missed a cycle");
  // Ratio two leaves one idle tick between counts
  prescale_two_a: assert property (q.prescale == 2'h1 && incTick |=> !incTick)
    else $error("prescaler by two counted twice in a row");

  // Wrap from all ones raises the one-cycle pulse
  wrap_flag_a: assert property (incTick && q.count == 16'hFFFF && !wrLow && !wrHigh
    |=> q.overflow && q.count == 16'h0000)
    else $error("wrap from all ones not flagged");
  wrap_only_a: assert property (q.overflow |-> q.count == 16'h0000)
    else $error("wrap pulse without a zero count");

  // Pin arming steps: a fall arms, disabling or a count write disarms
  arm_on_fall_a: assert property (q.enable && pinFall && !wrLow && !wrHigh |=> q.armed)
    else $error("falling edge did not arm the pin counter");
  disarm_off_a: assert property (!q.enable |=> !q.armed && !q.pendEdge)
    else $error("disabled counter kept pin state");
  write_disarm_a: assert property (wrLow || wrHigh |=> !q.armed && !q.pendEdge)
    else $error("count write left the pin counter armed");
  // Aligned mode parks an armed rise until the next instruction tick
  pend_set_a: assert property (q.enable && !q.asyncSel && pinRise && q.armed
    && !wrLow && !wrHigh |=> q.pendEdge)
    else $error("aligned pin edge not held");

  // Pin level moves only once the last two stages agree
  pin_agree_a: assert property (q.pinSync[1] == q.pinSync[2] |=> q.pinLevel == $past(q.pinSync[2]))
    else $error("pin level not taken from agreeing stages");
  pin_hold_a: assert property (q.pinSync[1] != q.pinSync[2] |=> $stable(q.pinLevel))
    else $error("pin level moved while stages disagree");

  // Bus steps: an access is taken in idle and answered one cycle later
  sequence apbTaken;
    q.phase == gated_timer_pkg::APB_IDLE && psel && penable;
  endsequence
  apb_answer_a: assert property (apbTaken |=> q.pready && q.phase == gated_timer_pkg::APB_ANSWER)
    else $error("access not answered after one wait state");
  apb_pulse_a: assert property (q.pready |=> !q.pready)
    else $error("ready stood for more than one cycle");
  bad_addr_a: assert property (apbTaken ##0 !addrHit |=> q.pslverr)
    else $error("unmapped offset answered without error");
  read_low_a: assert property (apbTaken ##0 !pwrite && paddr == gated_timer_pkg::OFF_COUNT_LOW
    |=> q.prdata == {24'h000000, $past(q.count[7:0])})
    else $error("low byte read returned the wrong value");

  // Clock enable low freezes every state bit; only reset disables this one
  freeze_hold_a: assert property (disable iff (!rstnSync) !ce |=> $stable(q))
    else $error("state moved with clock enable low");

endmodule

// *** sim/count_pin_model.sv ***
// Far-side model: count pin, gate pin and peripheral gate outputs
`timescale 1ns/1ps
module count_pin_model (
  input wire logic sys_clk,
  output logic externalCountInput,
  output logic gatePinInput,
  output gated_timer_pkg::gateSources_s gateSources
);
  // Idle levels: count pin high, every gate low
  initial
  begin
    externalCountInput = 1'h1;
    gatePinInput = 1'h0;
    gateSources = '0;
  end

  // One pin level, held ten clocks so the synchroniser and the instruction tick see it
  task automatic pinLevel(input logic lvl);
    @(posedge sys_clk);
    externalCountInput <= lvl;
    repeat (10) @(posedge sys_clk);
  endtask

  // Slow pulses, fall then rise, like a watch crystal source
  task automatic pulses(input int n);
    repeat (n)
    begin
      pinLevel(1'h0);
      pinLevel(1'h1);
    end
  endtask

  // Gate pin and peripheral outputs change together after an edge
  task automatic setGates(input logic pin, input logic [12:0] src);
    @(posedge sys_clk);
    gatePinInput <= pin;
    gateSources <= src;
  endtask
endmodule

// *** sim/gated_sixteen_bit_timer_counter_tb_top.sv ***
// Testbench of the gated 16-bit timer/counter
`timescale 1ns/1ps
module gated_sixteen_bit_timer_counter_tb_top;
  logic sys_clk, rstn, ce, psel, penable, pwrite, pready, pslverr, extPin, gatePin, ovf;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdData;
  logic [3:0] pstrb;
  logic [15:0] cnt, cnt0;
  gated_timer_pkg::gateSources_s gSrc;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  // Gate select code to source bit; code 0 is the gate pin
  int bitOf[14] = '{0, 12, 10, 11, 7, 8, 9, 5, 6, 3, 4, 1, 2, 0};
  // Source, prescale code and counts in 64 clocks
  int rCs[7] = '{1, 1, 1, 1, 0, 0, 3};
  int rPre[7] = '{0, 1, 2, 3, 0, 3, 0};
  int rExp[7] = '{64, 32, 16, 8, 16, 2, 0};

  // Clock enable driven by the bench, dropped once to check the freeze
  gated_timer_counter dut_u (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .externalCountInput(extPin), .gatePinInput(gatePin), .gateSources(gSrc),
    .countValue(cnt), .overflowPulse(ovf));
  count_pin_model far_u (.sys_clk(sys_clk), .externalCountInput(extPin), .gatePinInput(gatePin),
    .gateSources(gSrc));

  // 100 MHz clock
  initial
  begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Hang guard, far above the expected run length
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // APB transfer; entered just after an edge, request held until pready is sampled
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'h1;
    // Only the hang guard ends a wait that never sees pready
    do
      @(posedge sys_clk);
    while (pready !== 1'h1);
    rdData = prdata;
    cmp("pslverr", {31'h0, a > gated_timer_pkg::OFF_CLOCK_SELECT}, {31'h0, pslverr});
    psel <= 1'h0;
    penable <= 1'h0;
    // One idle edge, so the next call never raises psel again in this step
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d, 4'hF);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0, 4'hF);
    cmp("read data", exp, rdData);
  endtask

  // Counts gained over 64 clocks
  task automatic rate(input int exp);
    repeat (16) @(posedge sys_clk);
    cnt0 = cnt;
    repeat (64) @(posedge sys_clk);
    cmp("count delta", exp, {16'h0, cnt - cnt0});
  endtask

  initial
  begin
    rstn = 1'h0;
    ce = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'h1;
    repeat (3) @(posedge sys_clk);
    // Reset values, reserved bits, unmapped word; the gate level bit reads 1,
    // as the gate pin idles low and the reset polarity is active low
    for (int i = 0; i < 5; i++)
      rd(12'(4 * i), i == 3 ? 32'h100 : 32'h0);
    rd(12'h014, 32'h0);
    wr(gated_timer_pkg::OFF_TIMER_CONTROL, 32'hFFFFFF32);
    rd(gated_timer_pkg::OFF_TIMER_CONTROL, 32'h32);
    $display("Registers test done");
    // Byte loads, each keeps the other byte; masked strobe ignored
    wr(gated_timer_pkg::OFF_COUNT_LOW, 32'h34);
    wr(gated_timer_pkg::OFF_COUNT_HIGH, 32'h12);
    apb(1'h1, gated_timer_pkg::OFF_COUNT_LOW, 32'h99, 4'h0);
    cmp("count", 32'h1234, {16'h0, cnt});
    rd(gated_timer_pkg::OFF_COUNT_HIGH, 32'h12);
    rate(0);
    $display("Byte access test done");
    // Source and prescaler table
    for (int i = 0; i < 7; i++)
    begin
      wr(gated_timer_pkg::OFF_CLOCK_SELECT, 32'(rCs[i]));
      wr(gated_timer_pkg::OFF_TIMER_CONTROL, 32'h1 | 32'(rPre[i] << 4));
      rate(rExp[i]);
    end
    $display("Rate test done");
    // Gate mux: only the chosen source opens the gate
    wr(gated_timer_pkg::OFF_CLOCK_SELECT, 32'h1);
    wr(gated_timer_pkg::OFF_TIMER_CONTROL, 32'h1);
    for (int s = 0; s < 14; s++)
    begin
      wr(gated_timer_pkg::OFF_GATE_CONTROL, 32'h3 | 32'(s << 4));
      far_u.setGates(s == 0, s == 0 ? 13'h0 : 13'h1 << bitOf[s]);
      repeat (8) @(posedge sys_clk);
      rd(gated_timer_pkg::OFF_GATE_CONTROL, 32'h103 | 32'(s << 4));
      rate(64);
      far_u.setGates(s != 0, s == 0 ? 13'h1FFF : ~(13'h1 << bitOf[s]));
      rate(0);
    end
    // Active-low gate, then enable off with gate open, then free running
    far_u.setGates(1'h0, 13'h0);
    wr(gated_timer_pkg::OFF_GATE_CONTROL, 32'h11);
    rate(64);
    wr(gated_timer_pkg::OFF_TIMER_CONTROL, 32'h0);
    rate(0);
    wr(gated_timer_pkg::OFF_GATE_CONTROL, 32'h0);
    wr(gated_timer_pkg::OFF_TIMER_CONTROL, 32'h1);
    rate(64);
    // Clock enable low: the running count must not move
    ce <= 1'h0;
    rate(0);
    ce <= 1'h1;
    $display("Gate test done");
    // Wrap from all ones
    wr(gated_timer_pkg::OFF_TIMER_CONTROL, 32'h0);
    wr(gated_timer_pkg::OFF_COUNT_LOW, 32'hFD);
    wr(gated_timer_pkg::OFF_COUNT_HIGH, 32'hFF);
    wr(gated_timer_pkg::OFF_TIMER_CONTROL, 32'h1);
    for (int w = 0; w < 20 && ovf !== 1'h1; w++)
      @(posedge sys_clk);
    cmp("overflow", 32'h1, {31'h0, ovf});
    $display("Wrap test done");
    // Pin counting, immediate then instruction-aligned
    for (int a = 1; a >= 0; a--)
    begin
      wr(gated_timer_pkg::OFF_TIMER_CONTROL, 32'h0);
      wr(gated_timer_pkg::OFF_CLOCK_SELECT, 32'h2);
      far_u.pinLevel(1'h0);
      wr(gated_timer_pkg::OFF_COUNT_LOW, 32'h0);
      wr(gated_timer_pkg::OFF_COUNT_HIGH, 32'h0);
      wr(gated_timer_pkg::OFF_TIMER_CONTROL, 32'h1 | 32'(a << 1));
      far_u.pinLevel(1'h1);
      cmp("count", 32'h0, {16'h0, cnt});
      far_u.pulses(3);
      cmp("count", 32'h3, {16'h0, cnt});
      far_u.pinLevel(1'h0);
      wr(gated_timer_pkg::OFF_COUNT_LOW, 32'h10);
      far_u.pinLevel(1'h1);
      cmp("count", 32'h10, {16'h0, cnt});
      far_u.pulses(1);
      cmp("count", 32'h11, {16'h0, cnt});
    end
    $display("Pin test done");
    stop_test();
  end
endmodule
